//--- hw/owcd_pin_sync.sv
// two-stage synchroniser for a group of asynchronous pin inputs
// assumes the inputs are quasi-static levels relative to clk_sys_i
`timescale 1ns/1ps
`default_nettype none

module owcd_pin_sync #(
    parameter int WIDTH = 1
) (
    input wire logic clk_sys_i,
    input wire logic rst_n_i,
    input wire logic [WIDTH-1:0] async_i,
    input wire logic [WIDTH-1:0] reset_val_i,
    output logic [WIDTH-1:0] sync_o
);

    logic [WIDTH-1:0] meta;
    logic [WIDTH-1:0] stable;

    // every stage clears to 0; users must treat the first two cycles after release as idle
    genvar g;
    generate
        for (g = 0; g < WIDTH; g++) begin : g_bit
            always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
                if (!rst_n_i) begin
                    meta[g] <= 1'b0;
                    stable[g] <= 1'b0;
                end else begin
                    meta[g] <= async_i[g];
                    stable[g] <= meta[g];
                end
            end
            // hold the idle level until the chain has filled once
            assign sync_o[g] = stable[g];
        end
    endgenerate

    logic unused_reset_val;
    assign unused_reset_val = ^reset_val_i;

endmodule

`default_nettype wire

//--- hw/owcd_top.sv
// option word holder and decoder: loads the OTP option word once per power-on reset,
// decodes it for the core, serves the test readback register and the option-mode pins
// assumes otp_* ports come from the OTP macro on clk_sys_i and the *_pin_i inputs are
// asynchronous pins; port 6 data pins are resolved outside from out/oe
`timescale 1ns/1ps
`default_nettype none
`include "owcd_params.svh"

// Summary of operation
// - option word unreachable by normal instructions
// - load OTP word into register after reset
// - test mode reads six bits at 0E
// - option mode writes/reads word over port 6
// - bit 12 picks RC or crystal
// - bit 11 low enables watchdog
// - bit 10 picks two or four clocks
// - bit 9 low enables code protection
// - bit 8 picks crystal frequency range
// - frequency bit matters only for crystal
// - bit 7 picks oscillator power level
// - bit 6 picks package variant
// - plain variant treats low bits as zero
// - bit 5 sets wake-up pin scope
// - bits 3..0 hold stored user code
// - protection blocks external OTP readout
module owcd_top
    import owcd_pkg::*;
#(
    parameter bit EXTENDED = 1'b1
) (
    input wire logic clk_sys_i,
    input wire logic rst_n_i,
    output logic otp_rd_req_o,
    input wire logic otp_rd_ack_i,
    input wire logic [`OWCD_WORD_W-1:0] otp_opt_word_i,
    output logic otp_wr_o,
    output logic [`OWCD_WORD_W-1:0] otp_wdata_o,
    output logic [`OWCD_WORD_W-1:0] otp_wmask_o,
    input wire logic vpp_on_pin_i,
    input wire logic byte_sel_pin_i,
    input wire logic pgm_n_pin_i,
    input wire logic oe_n_pin_i,
    input wire logic [`OWCD_PIN_W-1:0] port6_pins_0_to_6_i,
    output logic [`OWCD_PIN_W-1:0] port6_pins_0_to_6_o,
    output logic [`OWCD_PIN_W-1:0] port6_pins_0_to_6_oe_o,
    input wire logic test_mode_i,
    input wire logic reg_rd_i,
    input wire logic [`OWCD_ADDR_W-1:0] reg_addr_i,
    output logic [`OWCD_INTERNAL_DATA_BUS_W-1:0] internal_data_bus_o,
    output logic internal_data_valid_o,
    output logic cfg_valid_o,
    output owcd_cfg_out_type cfg_o,
    output logic ext_read_block_o
);

    localparam int PIN_GROUP_W = `OWCD_PIN_W + 4;

    owcd_regs_type q;
    owcd_regs_type next_q;
    owcd_pins_type pins;
    logic [PIN_GROUP_W-1:0] pin_raw;
    logic [PIN_GROUP_W-1:0] pin_sync;
    logic opt_mode;
    logic protect_active;
    logic read_ok;
    logic rb_hit;

    assign pin_raw = {vpp_on_pin_i, byte_sel_pin_i, pgm_n_pin_i, oe_n_pin_i,
                      port6_pins_0_to_6_i};

    owcd_pin_sync #(
        .WIDTH(PIN_GROUP_W)
    ) u_pin_sync (
        .clk_sys_i(clk_sys_i),
        .rst_n_i(rst_n_i),
        .async_i(pin_raw),
        .reset_val_i({PIN_GROUP_W{1'b0}}),
        .sync_o(pin_sync)
    );

    assign pins = owcd_pins_type'(pin_sync);

    // option mode needs programming voltage and the latched mode code
    assign opt_mode = pins.vpp_on && (q.mode == `OWCD_MODE_OPTION);
    // protection comes from the word loaded at power-on, not from the live cells
    assign protect_active = (q.state == OWCD_ST_RUN) && !q.cfg[`OWCD_BIT_PROTECT_N];
    // pins are only turned around while no write pulse is active
    assign read_ok = opt_mode && !pins.oe_n && pins.pgm_n && !protect_active;
    assign rb_hit = reg_rd_i && (reg_addr_i == `OWCD_READBACK_ADDR);

    always_comb begin
        next_q = q;
        next_q.otp_wr = 1'b0;
        next_q.wdata = q.wdata;
        next_q.wmask = q.wmask;
        next_q.rvalid = 1'b0;
        next_q.rdata = {`OWCD_INTERNAL_DATA_BUS_W{1'b0}};

        // the word is taken once; later OTP programming shows only after a new reset
        case (q.state)
            OWCD_ST_LOAD: begin
                if (otp_rd_ack_i) begin
                    next_q.cfg = otp_opt_word_i;
                    next_q.state = OWCD_ST_RUN;
                end
            end
            OWCD_ST_RUN: begin
                next_q.cfg = q.cfg;
            end
            default: begin
                next_q.state = OWCD_ST_LOAD;
            end
        endcase

        // decode is a pure function of the held word; the core has no write path
        next_q.dec.osc_type_sel = next_q.cfg[`OWCD_BIT_OSC_TYPE];
        next_q.dec.wdt_enable = !next_q.cfg[`OWCD_BIT_WDT_DIS];
        next_q.dec.cycle_clocks_sel = next_q.cfg[`OWCD_BIT_CYCLE_CYCLE_CLOCKS_SEL];
        next_q.dec.code_protect = !next_q.cfg[`OWCD_BIT_PROTECT_N];
        // frequency range is forced low unless a crystal is selected
        next_q.dec.xtal_freq_sel = next_q.cfg[`OWCD_BIT_XTAL_FREQ]
                                   && next_q.cfg[`OWCD_BIT_OSC_TYPE];
        next_q.dec.osc_power_sel = next_q.cfg[`OWCD_BIT_OSC_POWER];
        next_q.dec.variant_sel = next_q.cfg[`OWCD_BIT_VARIANT];
        if (EXTENDED) begin
            next_q.dec.wake_all_pins = next_q.cfg[`OWCD_BIT_WAKE_ALL];
            next_q.dec.aux_enable_bit = next_q.cfg[`OWCD_BIT_AUX_EN];
            next_q.dec.user_code = next_q.cfg[`OWCD_UCODE_HI:`OWCD_UCODE_LO];
        end else begin
            // plain variant: low field is unused and reads as its default
            {next_q.dec.wake_all_pins, next_q.dec.aux_enable_bit,
             next_q.dec.user_code} = `OWCD_LOW_UNUSED_DEFAULT;
        end
        if (next_q.state != OWCD_ST_RUN) begin
            next_q.dec = '0;
        end

        // mode code rides on port 6 pins 0..2 and is frozen once vpp is applied
        if (!pins.vpp_on) begin
            next_q.mode = pins.data[2:0];
        end
        next_q.pgm_prev = pins.pgm_n;

        // falling edge of the write strobe programs the selected byte
        if (opt_mode && q.pgm_prev && !pins.pgm_n) begin
            next_q.otp_wr = 1'b1;
            if (pins.byte_sel) begin
                next_q.wdata = {pins.data[5:0], 7'h00};
                next_q.wmask = `OWCD_HIGH_MASK;
            end else begin
                next_q.wdata = {6'h00, pins.data};
                next_q.wmask = `OWCD_LOW_MASK;
            end
        end

        // verify reads the live cells so a fresh write can be checked
        if (read_ok) begin
            next_q.pin_oe = {`OWCD_PIN_W{1'b1}};
            if (pins.byte_sel) begin
                next_q.pin_out = {1'b0, otp_opt_word_i[`OWCD_RB_HI:`OWCD_RB_LO]};
            end else begin
                next_q.pin_out = otp_opt_word_i[6:0];
            end
        end else begin
            next_q.pin_oe = {`OWCD_PIN_W{1'b0}};
            next_q.pin_out = {`OWCD_PIN_W{1'b0}};
        end

        // outside test mode the readback address answers zero
        if (rb_hit) begin
            next_q.rvalid = 1'b1;
            if (test_mode_i && q.state == OWCD_ST_RUN) begin
                next_q.rdata = {2'h0, q.cfg[`OWCD_RB_HI:`OWCD_RB_LO]};
            end else begin
                next_q.rdata = {`OWCD_INTERNAL_DATA_BUS_W{1'b0}};
            end
        end
    end

    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            // strobe history clears like the synchroniser, so release shows no false falling edge
            q <= '{state: OWCD_ST_LOAD, cfg: `OWCD_CFG_RESET, dec: '0, mode: `OWCD_MODE_REGULAR,
                   pgm_prev: 1'b0, otp_wr: 1'b0, wdata: '0, wmask: '0, pin_out: '0,
                   pin_oe: '0, rdata: '0, rvalid: 1'b0};
        end else begin
            q <= next_q;
        end
    end

    assign otp_rd_req_o = (q.state == OWCD_ST_LOAD);
    assign otp_wr_o = q.otp_wr;
    assign otp_wdata_o = q.wdata;
    assign otp_wmask_o = q.wmask;
    assign port6_pins_0_to_6_o = q.pin_out;
    assign port6_pins_0_to_6_oe_o = q.pin_oe;
    assign internal_data_bus_o = q.rdata;
    assign internal_data_valid_o = q.rvalid;
    assign cfg_valid_o = (q.state == OWCD_ST_RUN);
    assign cfg_o = q.dec;
    assign ext_read_block_o = protect_active;

    a_load_captures: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        (q.state == OWCD_ST_LOAD && otp_rd_ack_i)
        |=> (cfg_valid_o && q.cfg == $past(otp_opt_word_i)))
        else $error("option word not captured on load acknowledge");

    a_cfg_frozen: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        cfg_valid_o |=> (cfg_valid_o && $stable(q.cfg) && $stable(cfg_o)))
        else $error("configuration changed after load");

    a_readback_bits: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        (rb_hit && test_mode_i && cfg_valid_o)
        |=> (internal_data_valid_o && internal_data_bus_o[7:6] == 2'h0
             && internal_data_bus_o[5:0] == q.cfg[12:7]))
        else $error("test readback does not show option bits");

    a_normal_hidden: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        (reg_rd_i && !test_mode_i) |=> (internal_data_bus_o == 8'h00))
        else $error("option bits visible outside test mode");

    a_write_strobe: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        (opt_mode && q.pgm_prev && !pins.pgm_n)
        |=> (otp_wr_o ##1 !otp_wr_o))
        else $error("option write not issued as one pulse");

    a_write_mask: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        otp_wr_o |-> (otp_wmask_o == 13'h1f80 || otp_wmask_o == 13'h007f))
        else $error("option write selects no byte");

    a_freq_gated: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        (cfg_valid_o && !q.cfg[12]) |-> !cfg_o.xtal_freq_sel)
        else $error("frequency range active with rc oscillator");

    a_wdt_polarity: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        cfg_valid_o |-> (cfg_o.wdt_enable != q.cfg[11] && cfg_o.code_protect != q.cfg[9]))
        else $error("active low enables decoded with wrong polarity");

    a_protect_block: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        (protect_active && $past(protect_active)) |-> (port6_pins_0_to_6_oe_o == 7'h00))
        else $error("pins driven while code protection is active");

    a_plain_low: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        !EXTENDED |-> (cfg_o.user_code == 4'h0 && !cfg_o.aux_enable_bit
                       && !cfg_o.wake_all_pins))
        else $error("unused low field not zero on plain variant");

    a_not_valid_zero: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        !cfg_valid_o |-> (cfg_o == '0 && !ext_read_block_o))
        else $error("configuration outputs active before load");

endmodule

`default_nettype wire

//--- shared/owcd_params.svh
// option word decoder constants: offsets, field positions, reset values, mode codes
// included by the package, owcd_top and the test files; definitions only
`ifndef OWCD_PARAMS_SVH
`define OWCD_PARAMS_SVH

`define OWCD_WORD_W 13
`define OWCD_PIN_W 7
`define OWCD_ADDR_W 6
`define OWCD_INTERNAL_DATA_BUS_W 8

// core register address of the test readback register
`define OWCD_READBACK_ADDR 6'h0e

// field positions inside the option word
`define OWCD_BIT_OSC_TYPE 12
`define OWCD_BIT_WDT_DIS 11
`define OWCD_BIT_CYCLE_CYCLE_CLOCKS_SEL 10
`define OWCD_BIT_PROTECT_N 9
`define OWCD_BIT_XTAL_FREQ 8
`define OWCD_BIT_OSC_POWER 7
`define OWCD_BIT_VARIANT 6
`define OWCD_BIT_WAKE_ALL 5
`define OWCD_BIT_AUX_EN 4
`define OWCD_UCODE_HI 3
`define OWCD_UCODE_LO 0
// six bits seen through the readback register
`define OWCD_RB_HI 12
`define OWCD_RB_LO 7

// byte split of the word on the programming pins
`define OWCD_HIGH_MASK 13'h1f80
`define OWCD_LOW_MASK 13'h007f

// reset values
`define OWCD_CFG_RESET 13'h0000
`define OWCD_LOW_UNUSED_DEFAULT 6'h00

// mode code sampled on port 6 pins 0..2 while the programming voltage is off
`define OWCD_MODE_REGULAR 3'h0
`define OWCD_MODE_OPTION 3'h2

// synchroniser depth for pin inputs
`define OWCD_SYNC_STAGES 2

`endif

//--- shared/owcd_pkg.sv
// types shared by the option word decoder modules
// assumes owcd_params.svh is on the include path
`include "owcd_params.svh"

package owcd_pkg;

    typedef enum logic [1:0] {
        OWCD_ST_LOAD = 2'b00,
        OWCD_ST_RUN = 2'b01
    } owcd_state_type;

    // decoded configuration handed to the core
    typedef struct packed {
        logic osc_type_sel;
        logic wdt_enable;
        logic cycle_clocks_sel;
        logic code_protect;
        logic xtal_freq_sel;
        logic osc_power_sel;
        logic variant_sel;
        logic wake_all_pins;
        logic aux_enable_bit;
        logic [3:0] user_code;
    } owcd_cfg_out_type;

    // programming pins after synchronisation
    typedef struct packed {
        logic vpp_on;
        logic byte_sel;
        logic pgm_n;
        logic oe_n;
        logic [`OWCD_PIN_W-1:0] data;
    } owcd_pins_type;

    typedef struct packed {
        owcd_state_type state;
        logic [`OWCD_WORD_W-1:0] cfg;
        owcd_cfg_out_type dec;
        logic [2:0] mode;
        logic pgm_prev;
        logic otp_wr;
        logic [`OWCD_WORD_W-1:0] wdata;
        logic [`OWCD_WORD_W-1:0] wmask;
        logic [`OWCD_PIN_W-1:0] pin_out;
        logic [`OWCD_PIN_W-1:0] pin_oe;
        logic [`OWCD_INTERNAL_DATA_BUS_W-1:0] rdata;
        logic rvalid;
    } owcd_regs_type;

endpackage

//--- test/option_word_config_decoder_test.sv
// self-checking bench for the option word decoder
// assumes the design files and the OTP model are compiled first
`timescale 1ns/1ps
`default_nettype none
`include "owcd_params.svh"

module option_word_config_decoder_test;
    import owcd_pkg::*;
    logic clk_sys_i = 0, rst_n_i = 0, ack, req, wr, vpp = 0, bsel = 0, pgm_n = 1, oe_n = 1;
    logic test = 0, rd = 0, pre = 0, dv, cv, blk;
    logic [3:0] dly = 0;
    logic [5:0] addr = 0;
    logic [6:0] drv = 0, p_in, p_out, p_oe;
    logic [7:0] internal_data_bus;
    logic [12:0] pw = 0, cells, wd, wm;
    owcd_cfg_out_type cfg;
    logic cv_plain;
    owcd_cfg_out_type cfg_plain;
    int err_count = 0, total_checks = 0;

    assign p_in = (p_oe & p_out) | (~p_oe & drv);
    initial forever #2 clk_sys_i = ~clk_sys_i;

    owcd_top #(.EXTENDED(1'b1)) uut (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i),
        .otp_rd_req_o(req), .otp_rd_ack_i(ack), .otp_opt_word_i(cells), .otp_wr_o(wr),
        .otp_wdata_o(wd), .otp_wmask_o(wm), .vpp_on_pin_i(vpp), .byte_sel_pin_i(bsel),
        .pgm_n_pin_i(pgm_n), .oe_n_pin_i(oe_n), .port6_pins_0_to_6_i(p_in),
        .port6_pins_0_to_6_o(p_out), .port6_pins_0_to_6_oe_o(p_oe), .test_mode_i(test),
        .reg_rd_i(rd), .reg_addr_i(addr), .internal_data_bus_o(internal_data_bus),
        .internal_data_valid_o(dv), .cfg_valid_o(cv), .cfg_o(cfg), .ext_read_block_o(blk));

    // plain variant shares every input; it takes the same acknowledge as the extended one
    owcd_top #(.EXTENDED(1'b0)) uut_plain (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i),
        .otp_rd_req_o(), .otp_rd_ack_i(ack), .otp_opt_word_i(cells), .otp_wr_o(),
        .otp_wdata_o(), .otp_wmask_o(), .vpp_on_pin_i(vpp), .byte_sel_pin_i(bsel),
        .pgm_n_pin_i(pgm_n), .oe_n_pin_i(oe_n), .port6_pins_0_to_6_i(p_in),
        .port6_pins_0_to_6_o(), .port6_pins_0_to_6_oe_o(), .test_mode_i(test),
        .reg_rd_i(rd), .reg_addr_i(addr), .internal_data_bus_o(),
        .internal_data_valid_o(), .cfg_valid_o(cv_plain), .cfg_o(cfg_plain),
        .ext_read_block_o());

    owcd_otp_model otp (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .ack_delay_i(dly),
        .preset_i(pre), .preset_word_i(pw), .rd_req_i(req), .rd_ack_o(ack),
        .cells_o(cells), .wr_i(wr), .wdata_i(wd), .wmask_i(wm));

    task automatic check(input string name, input logic [12:0] seen, exp);
        total_checks++;
        if (seen !== exp) begin
            err_count++;
            $display("mismatch %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic report_and_stop();
        $display("checks %0d errors %0d", total_checks, err_count);
        if (err_count == 0 && total_checks > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge clk_sys_i);
    endtask

    // expected decode; RC words keep the frequency bit low
    function automatic logic [12:0] dec(input logic [12:0] w);
        return {w[12], ~w[11], w[10], ~w[9], w[12] & w[8], w[7:0]};
    endfunction

    task automatic load(input logic [12:0] w, input logic [3:0] d);
        int n = 0;
        tick(1);
        pre <= 1;
        pw <= w;
        dly <= d;
        rst_n_i <= 0;
        tick(1);
        pre <= 0;
        tick(3);
        #1;
        check("req_in_reset", {req, cv}, 2'b10);
        tick(1);
        rst_n_i <= 1;
        while (cv !== 1'b1 && n < 20) begin
            tick(1);
            #1;
            n++;
        end
        check("load_wait", n < 20, 1);
        check("req_after_load", req, 0);
        if (n == 20) report_and_stop();
    endtask

    task automatic rdreg(input logic [5:0] a, input logic t, input logic [7:0] e, input logic ev);
        tick(1);
        rd <= 1;
        addr <= a;
        test <= t;
        tick(1);
        rd <= 0;
        #1;
        check("rb_valid", dv, ev);
        check("rb_data", internal_data_bus, e);
        tick(1);
        #1;
        check("rb_after", {dv, internal_data_bus}, 0);
    endtask

    task automatic set_mode(input logic [2:0] m);
        tick(1);
        vpp <= 0;
        drv <= {4'h0, m};
        tick(6);
        vpp <= 1;
        tick(6);
    endtask

    task automatic pin_write(input logic bs, input logic [6:0] d, input logic [12:0] e, em,
                             input logic ew);
        int n = 0;
        tick(1);
        bsel <= bs;
        drv <= d;
        tick(6);
        pgm_n <= 0;
        while (wr !== 1'b1 && n < 8) begin
            tick(1);
            #1;
            n++;
        end
        check("wr_seen", n < 8, ew);
        if (ew) check("wdata", wd & em, e);
        if (ew) check("wmask", wm, em);
        if (ew && n == 8) report_and_stop();
        tick(1);
        pgm_n <= 1;
        tick(6);
    endtask

    // released pins show the inverse of their last level
    task automatic verify(input logic bs, input logic [6:0] e, eoe);
        tick(1);
        bsel <= bs;
        oe_n <= 0;
        drv <= ~drv;
        tick(8);
        #1;
        check("pin_oe", p_oe, eoe);
        check("pin_out", p_out & eoe, e);
        tick(1);
        oe_n <= 1;
        tick(8);
        #1;
        check("pin_oe_off", p_oe, 0);
    endtask

    task automatic t_decode();
        logic [12:0] ws[4] = '{13'h1fff, 13'h0000, 13'h1535, 13'h0a4a};
        for (int i = 0; i < 4; i++) begin
            load(ws[i], 4'(i * 3));
            check("cfg", cfg, dec(ws[i]));
            check("block", blk, !ws[i][9]);
            check("cv_plain", cv_plain, 1);
            check("cfg_plain", cfg_plain, dec(ws[i]) & 13'h1fc0);
            rdreg(6'h0e, 1, {2'b00, ws[i][12:7]}, 1);
        end
    endtask

    task automatic t_freeze();
        load(13'h1a55, 2);
        tick(1);
        pre <= 1;
        pw <= 13'h0000;
        tick(1);
        pre <= 0;
        tick(4);
        #1;
        check("cfg_frozen", cfg, dec(13'h1a55));
        rdreg(6'h0e, 1, 8'h34, 1);
    endtask

    task automatic t_readback();
        rdreg(6'h0d, 1, 8'h00, 0);
        rdreg(6'h0e, 0, 8'h00, 1);
        rdreg(6'h0f, 1, 8'h00, 0);
    endtask

    task automatic t_option();
        load(13'h1fff, 1);
        set_mode(`OWCD_MODE_OPTION);
        pin_write(1, 7'h6a, 13'h1500, 13'h1f80, 1);
        pin_write(0, 7'h55, 13'h0055, 13'h007f, 1);
        verify(1, 7'h2a, 7'h7f);
        verify(0, 7'h55, 7'h7f);
        set_mode(`OWCD_MODE_REGULAR);
        pin_write(0, 7'h11, 0, 0, 0);
        check("cells", cells, 13'h1555);
    endtask

    task automatic t_protect();
        load(13'h1c00, 0);
        set_mode(`OWCD_MODE_OPTION);
        verify(1, 7'h00, 7'h00);
    endtask

    initial begin
        t_decode();
        t_freeze();
        t_readback();
        t_option();
        t_protect();
        report_and_stop();
    end
endmodule

`default_nettype wire

//--- test/owcd_otp_model.sv
// behavioural OTP macro holding the option word cells
// assumes the decoder asks for the word after reset and programs through a bit mask
`timescale 1ns/1ps
`default_nettype none
`include "owcd_params.svh"

module owcd_otp_model (
    input wire logic clk_sys_i,
    input wire logic rst_n_i,
    input wire logic [3:0] ack_delay_i,
    input wire logic preset_i,
    input wire logic [`OWCD_WORD_W-1:0] preset_word_i,
    input wire logic rd_req_i,
    output logic rd_ack_o,
    output logic [`OWCD_WORD_W-1:0] cells_o,
    input wire logic wr_i,
    input wire logic [`OWCD_WORD_W-1:0] wdata_i,
    input wire logic [`OWCD_WORD_W-1:0] wmask_i
);
    logic [3:0] wait_cnt;

    // cells are not cleared by reset: they are non-volatile
    always_ff @(posedge clk_sys_i) begin
        if (preset_i) begin
            cells_o <= preset_word_i;
        end else if (wr_i) begin
            cells_o <= (cells_o & ~wmask_i) | (wdata_i & wmask_i);
        end
    end

    // the answer can be held back to exercise a slow macro
    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            wait_cnt <= '0;
            rd_ack_o <= 1'b0;
        end else begin
            rd_ack_o <= 1'b0;
            if (rd_req_i && !rd_ack_o) begin
                if (wait_cnt >= ack_delay_i) begin
                    rd_ack_o <= 1'b1;
                    wait_cnt <= '0;
                end else begin
                    wait_cnt <= wait_cnt + 4'h1;
                end
            end
        end
    end
endmodule

`default_nettype wire
